// file: common/fnd_pkg.sv
package fnd_pkg;

    // ----------------------------------------
    // Operating modes of the feedback divider
    // ----------------------------------------
    typedef enum logic [1:0] {
        FND_MODE_INT = 2'b00,
        FND_MODE_FRAC = 2'b01,
        FND_MODE_EXACT = 2'b10
    } fnd_mode_t;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [23:0] wdata;
        logic we;
        logic re;
    } fnd_reg_req_t;

    typedef struct packed {
        logic [23:0] frac_word;
        logic [23:0] step_div;
        logic exact_en;
    } fnd_mod_cfg_t;

    typedef struct packed {
        logic [23:0] acc;
        logic [23:0] cnt;
        logic carry;
        logic strobe;
    } fnd_mod_state_t;

    typedef struct packed {
        logic [18:0] int_ratio;
        logic [23:0] frac_word;
        logic [23:0] step_div;
        logic mod_en;
        logic bypass;
        logic [5:0] out_div;
        logic [23:0] rdata;
        logic rvalid;
        logic [19:0] ndiv;
        logic nvalid;
        logic [5:0] ratio;
        fnd_mode_t mode;
    } fnd_top_state_t;

endpackage

// file: common/fnd_regs.svh
`ifndef FND_REGS_SVH
`define FND_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FND_OFS_INT 8'h03
`define FND_OFS_FRAC 8'h04
`define FND_OFS_MODCFG 8'h06
`define FND_OFS_EXACT 8'h0c
`define FND_OFS_OUTDIV 8'h16
`define FND_OFS_STATUS 8'h1e

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FND_BIT_MOD_EN 11
`define FND_BIT_BYPASS 7
`define FND_OUTDIV_MSB 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FND_RST_INT 19'h00000
`define FND_RST_FRAC 24'h000000
`define FND_RST_EXACT 24'h000000
`define FND_RST_MOD_EN 1'b0
`define FND_RST_BYPASS 1'b1
`define FND_RST_OUTDIV 6'h01

`endif

// file: tb/fnd_frac_divider_test.sv
`timescale 1ns/1ps
`include "fnd_regs.svh"

module fnd_frac_divider_test import fnd_pkg::*; ;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    fnd_reg_req_t reg_req = '0;
    logic pd_tick = 1'b0;
    logic [23:0] rdata;
    logic rvalid;
    logic [19:0] ndiv;
    logic ndiv_valid;
    logic [5:0] ratio;
    fnd_mode_t mode;
    logic [19:0] q[$];
    int n_fail = 0;
    int compares = 0;

    // ----------------------------------------
    // Clock, device and division value collector
    // ----------------------------------------
    always #5 clock_in = ~clock_in;

    fnd_frac_divider fnd_frac_divider_inst (
        .clock_in(clock_in), .resetn_in(resetn_in), .reg_req_in(reg_req),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .pd_tick_in(pd_tick),
        .ndiv_out(ndiv), .ndiv_valid_out(ndiv_valid), .out_div_ratio_out(ratio),
        .mode_out(mode)
    );

    // Records every division value that the block announces
    always @(posedge clock_in) begin
        if (ndiv_valid === 1'b1) q.push_back(ndiv);
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic results();
        if (n_fail == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clock_in);
        reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clock_in);
        reg_req.we <= 1'b0;
    endtask

    // Read answer stands for one cycle after the sampling edge
    task automatic rd(input logic [7:0] a, input logic [23:0] exp);
        @(posedge clock_in);
        reg_req <= '{addr: a, wdata: 24'h000000, we: 1'b0, re: 1'b1};
        @(posedge clock_in);
        reg_req.re <= 1'b0;
        #1;
        chk({23'h000000, rvalid}, 24'h000001);
        chk(rdata, exp);
    endtask

    // Ticks on n consecutive cycles, waits boundedly for n values, returns their sum
    task automatic ticks(input int n, output int sum);
        q.delete();
        repeat (n) begin
            @(posedge clock_in);
            pd_tick <= 1'b1;
        end
        @(posedge clock_in);
        pd_tick <= 1'b0;
        for (int i = 0; i < 20 && q.size() < n; i++) @(posedge clock_in);
        repeat (3) @(posedge clock_in);
        sum = 0;
        if (q.size() != n) begin
            n_fail++;
            $display("Error at %0t: division values missing", $time);
            results();
        end else begin
            foreach (q[i]) sum += q[i];
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(`FND_OFS_INT, 24'h000000);
        rd(`FND_OFS_FRAC, 24'h000000);
        rd(`FND_OFS_EXACT, 24'h000000);
        rd(`FND_OFS_MODCFG, 24'h000080);
        rd(`FND_OFS_OUTDIV, 24'h000001);
        rd(8'h55, 24'h000000);
        chk({22'h000000, mode}, {22'h000000, FND_MODE_INT});
        chk({18'h00000, ratio}, 24'h000001);
    endtask

    task automatic t_regs();
        wr(`FND_OFS_INT, 24'hffffff);
        rd(`FND_OFS_INT, 24'h07ffff);
        wr(`FND_OFS_FRAC, 24'hffffff);
        rd(`FND_OFS_FRAC, 24'hffffff);
        wr(`FND_OFS_EXACT, 24'ha5a5a5);
        rd(`FND_OFS_EXACT, 24'ha5a5a5);
        wr(`FND_OFS_MODCFG, 24'hfff87f);
        rd(`FND_OFS_MODCFG, 24'h000800);
        wr(`FND_OFS_EXACT, 24'h000000);
        wr(`FND_OFS_MODCFG, 24'h000080);
    endtask

    // Write then read on the next cycle, then a read and a write in one cycle
    task automatic t_b2b();
        @(posedge clock_in);
        reg_req <= '{addr: `FND_OFS_FRAC, wdata: 24'h5a5a5a, we: 1'b1, re: 1'b0};
        @(posedge clock_in);
        reg_req <= '{addr: `FND_OFS_FRAC, wdata: 24'h000000, we: 1'b0, re: 1'b1};
        @(posedge clock_in);
        reg_req <= '{addr: `FND_OFS_FRAC, wdata: 24'h123456, we: 1'b1, re: 1'b1};
        #1;
        chk(rdata, 24'h5a5a5a);
        @(posedge clock_in);
        reg_req <= '{addr: `FND_OFS_FRAC, wdata: 24'h000000, we: 1'b0, re: 1'b0};
        #1;
        chk({23'h000000, rvalid}, 24'h000001);
        chk(rdata, 24'h5a5a5a);
        rd(`FND_OFS_FRAC, 24'h123456);
    endtask

    task automatic t_outdiv();
        logic [5:0] sel[4] = '{6'h00, 6'h02, 6'h03, 6'h3e};
        logic [5:0] exp[4] = '{6'h01, 6'h02, 6'h02, 6'h3e};
        for (int i = 0; i < 4; i++) begin
            wr(`FND_OFS_OUTDIV, {18'h00000, sel[i]});
            repeat (2) @(posedge clock_in);
            chk({18'h00000, ratio}, {18'h00000, exp[i]});
        end
    endtask

    task automatic t_int();
        int s;
        wr(`FND_OFS_INT, 24'h000014);
        wr(`FND_OFS_FRAC, 24'h800000);
        ticks(3, s);
        chk(s, 24'h00003c);
        wr(`FND_OFS_INT, 24'h07fffc);
        ticks(1, s);
        chk(q[0], 24'h07fffc);
    endtask

    task automatic t_frac_half();
        int s;
        wr(`FND_OFS_INT, 24'h000038);
        wr(`FND_OFS_MODCFG, 24'h000800);
        repeat (2) @(posedge clock_in);
        chk({22'h000000, mode}, {22'h000000, FND_MODE_FRAC});
        ticks(4, s);
        chk(q[0], 24'h000038);
        chk(q[1], 24'h000039);
        chk(q[2], 24'h000038);
        chk(q[3], 24'h000039);
    endtask

    task automatic t_frac_tenth();
        int s;
        wr(`FND_OFS_MODCFG, 24'h000080);
        wr(`FND_OFS_FRAC, 24'h19999a);
        wr(`FND_OFS_MODCFG, 24'h000800);
        ticks(10, s);
        chk(s, 24'h000231);
        rd(`FND_OFS_STATUS, 24'h000004);
    endtask

    task automatic t_exact();
        int s;
        wr(`FND_OFS_MODCFG, 24'h000080);
        wr(`FND_OFS_INT, 24'h000038);
        wr(`FND_OFS_EXACT, 24'h00000a);
        wr(`FND_OFS_FRAC, 24'h19999a);
        wr(`FND_OFS_MODCFG, 24'h000800);
        repeat (2) @(posedge clock_in);
        chk({22'h000000, mode}, {22'h000000, FND_MODE_EXACT});
        ticks(10, s);
        chk(s, 24'h000231);
        rd(`FND_OFS_STATUS, 24'h000000);
        ticks(20, s);
        chk(s, 24'h000462);
        rd(`FND_OFS_STATUS, 24'h000000);
        wr(`FND_OFS_FRAC, 24'h333334);
        ticks(10, s);
        chk(s, 24'h000232);
        rd(`FND_OFS_STATUS, 24'h000000);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clock_in);
        resetn_in <= 1'b1;
        t_reset();
        t_regs();
        t_b2b();
        t_outdiv();
        t_int();
        t_frac_half();
        t_frac_tenth();
        t_exact();
        results();
    end
endmodule

// file: verilog/fnd_frac_divider.sv
`timescale 1ns/1ps
`include "fnd_regs.svh"

// Functional notes
// - Integer ratio held as 19-bit unsigned
// - Fractional word held as 24-bit unsigned
// - Modulator 24 bits, step fpd over 2^24
// - Modulus fixed power of two, not programmable
// - Binary-exact ratios give zero error
// - Exact mode zero error on gcd grid
// - Exact mode keeps full 24-bit accumulator
// - Output divider select 2h divides by two
// - Fraction equals word over 2^24

module fnd_frac_divider import fnd_pkg::*; (
    // Clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // Register port
    input wire fnd_reg_req_t reg_req_in,
    output logic [23:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Phase detector rate enable
    input wire logic pd_tick_in,
    // Divider results
    output logic [19:0] ndiv_out,
    output logic ndiv_valid_out,
    output logic [5:0] out_div_ratio_out,
    output fnd_mode_t mode_out
);

    fnd_top_state_t s_r;
    fnd_top_state_t s_nxt;
    fnd_mod_cfg_t mod_cfg;
    logic mod_carry;
    logic mod_strobe;
    logic [23:0] mod_phase;
    logic wr_int;
    logic wr_frac;

    // ----------------------------------------
    // Modulator
    // ----------------------------------------
    assign mod_cfg.frac_word = s_r.frac_word;
    assign mod_cfg.step_div = s_r.step_div;
    assign mod_cfg.exact_en = (s_r.mode == FND_MODE_EXACT);

    fnd_modulator fnd_modulator_inst (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .tick_in(pd_tick_in),
        .run_in(s_r.mode != FND_MODE_INT),
        .cfg_in(mod_cfg),
        .carry_out(mod_carry),
        .strobe_out(mod_strobe),
        .phase_out(mod_phase)
    );

    // ----------------------------------------
    // Registers, mode decode and divider result
    // ----------------------------------------
    assign wr_int = reg_req_in.we && (reg_req_in.addr == `FND_OFS_INT);
    assign wr_frac = reg_req_in.we && (reg_req_in.addr == `FND_OFS_FRAC);

    always_comb begin
        s_nxt = s_r;
        // Register writes
        if (wr_int) begin
            s_nxt.int_ratio = reg_req_in.wdata[18:0];
        end
        if (wr_frac) begin
            s_nxt.frac_word = reg_req_in.wdata;
        end
        if (reg_req_in.we && (reg_req_in.addr == `FND_OFS_EXACT)) begin
            s_nxt.step_div = reg_req_in.wdata;
        end
        if (reg_req_in.we && (reg_req_in.addr == `FND_OFS_MODCFG)) begin
            s_nxt.mod_en = reg_req_in.wdata[`FND_BIT_MOD_EN];
            s_nxt.bypass = reg_req_in.wdata[`FND_BIT_BYPASS];
        end
        if (reg_req_in.we && (reg_req_in.addr == `FND_OFS_OUTDIV)) begin
            s_nxt.out_div = reg_req_in.wdata[`FND_OUTDIV_MSB:0];
        end
        // Register reads, unmapped offsets return zero
        s_nxt.rvalid = reg_req_in.re;
        if (reg_req_in.re) begin
            case (reg_req_in.addr)
                `FND_OFS_INT: s_nxt.rdata = {5'h00, s_r.int_ratio};
                `FND_OFS_FRAC: s_nxt.rdata = s_r.frac_word;
                `FND_OFS_EXACT: s_nxt.rdata = s_r.step_div;
                `FND_OFS_MODCFG: begin
                    s_nxt.rdata = 24'h000000;
                    s_nxt.rdata[`FND_BIT_MOD_EN] = s_r.mod_en;
                    s_nxt.rdata[`FND_BIT_BYPASS] = s_r.bypass;
                end
                `FND_OFS_OUTDIV: s_nxt.rdata = {18'h00000, s_r.out_div};
                `FND_OFS_STATUS: s_nxt.rdata = mod_phase;
                default: s_nxt.rdata = 24'h000000;
            endcase
        end
        // Mode: a zero step divisor means plain binary fractional mode
        if (!s_r.mod_en || s_r.bypass) begin
            s_nxt.mode = FND_MODE_INT;
        end else if (s_r.step_div != 24'h000000) begin
            s_nxt.mode = FND_MODE_EXACT;
        end else begin
            s_nxt.mode = FND_MODE_FRAC;
        end
        // Division value for each phase detector cycle
        s_nxt.nvalid = mod_strobe;
        if (mod_strobe) begin
            unique case (s_r.mode)
                FND_MODE_INT: s_nxt.ndiv = {1'b0, s_r.int_ratio};
                FND_MODE_FRAC, FND_MODE_EXACT: begin
                    s_nxt.ndiv = {1'b0, s_r.int_ratio} + {19'h00000, mod_carry};
                end
                default: s_nxt.ndiv = {1'b0, s_r.int_ratio};
            endcase
        end
        // Output divider: 0 or 1 is the fundamental, else the value with bit 0 cleared
        if (s_r.out_div < 6'h02) begin
            s_nxt.ratio = 6'h01;
        end else begin
            s_nxt.ratio = {s_r.out_div[5:1], 1'b0};
        end
    end

    // State register
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= '0;
            s_r.int_ratio <= `FND_RST_INT;
            s_r.frac_word <= `FND_RST_FRAC;
            s_r.step_div <= `FND_RST_EXACT;
            s_r.mod_en <= `FND_RST_MOD_EN;
            s_r.bypass <= `FND_RST_BYPASS;
            s_r.out_div <= `FND_RST_OUTDIV;
            s_r.ratio <= 6'h01;
            s_r.mode <= FND_MODE_INT;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_out = s_r.rdata;
    assign reg_rvalid_out = s_r.rvalid;
    assign ndiv_out = s_r.ndiv;
    assign ndiv_valid_out = s_r.nvalid;
    assign out_div_ratio_out = s_r.ratio;
    assign mode_out = s_r.mode;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_int_store;
        @(posedge clock_in) disable iff (!resetn_in)
        wr_int |=> (s_r.int_ratio == $past(reg_req_in.wdata[18:0]));
    endproperty
    a_int_store: assert property (p_int_store) else $error("integer ratio not stored");

    property p_frac_store;
        @(posedge clock_in) disable iff (!resetn_in)
        wr_frac ##1 (reg_req_in.re && reg_req_in.addr == `FND_OFS_FRAC && !wr_frac)
            |=> (reg_rvalid_out && reg_rdata_out == $past(reg_req_in.wdata, 2));
    endproperty
    a_frac_store: assert property (p_frac_store) else $error("fraction readback wrong");

    property p_ndiv_sum;
        @(posedge clock_in) disable iff (!resetn_in)
        (mod_strobe && s_r.mode != FND_MODE_INT) |=>
            ndiv_valid_out && (ndiv_out == {1'b0, $past(s_r.int_ratio)} + {19'h0, $past(mod_carry)});
    endproperty
    a_ndiv_sum: assert property (p_ndiv_sum) else $error("division value wrong");

    property p_int_mode;
        @(posedge clock_in) disable iff (!resetn_in)
        (pd_tick_in && s_r.mode == FND_MODE_INT && s_nxt.mode == FND_MODE_INT) ##1 mod_strobe
            |=> (ndiv_out == {1'b0, $past(s_r.int_ratio)});
    endproperty
    a_int_mode: assert property (p_int_mode) else $error("integer mode not plain");

    property p_tick_lat;
        @(posedge clock_in) disable iff (!resetn_in)
        pd_tick_in |-> ##2 ndiv_valid_out;
    endproperty
    a_tick_lat: assert property (p_tick_lat) else $error("result latency wrong");

    property p_hold;
        @(posedge clock_in) disable iff (!resetn_in)
        !mod_strobe |=> $stable(ndiv_out);
    endproperty
    a_hold: assert property (p_hold) else $error("division value moved without tick");

    property p_outdiv2;
        @(posedge clock_in) disable iff (!resetn_in)
        (s_r.out_div == 6'h02) |=> (out_div_ratio_out == 6'h02);
    endproperty
    a_outdiv2: assert property (p_outdiv2) else $error("divide by two missing");

    property p_exact_mode;
        @(posedge clock_in) disable iff (!resetn_in)
        (s_r.mod_en && !s_r.bypass && s_r.step_div != 24'h000000) |=>
            (mode_out == FND_MODE_EXACT);
    endproperty
    a_exact_mode: assert property (p_exact_mode) else $error("exact mode not entered");

endmodule

// file: verilog/fnd_modulator.sv
`timescale 1ns/1ps
`include "fnd_regs.svh"

module fnd_modulator import fnd_pkg::*; (
    // Clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // Control
    input wire logic tick_in,
    input wire logic run_in,
    input wire fnd_mod_cfg_t cfg_in,
    // Result
    output logic carry_out,
    output logic strobe_out,
    output logic [23:0] phase_out
);

    fnd_mod_state_t s_r;
    fnd_mod_state_t s_nxt;
    logic [24:0] sum;
    logic period_end;

    // ----------------------------------------
    // Phase accumulator over a fixed 2^24 modulus
    // ----------------------------------------
    assign sum = {1'b0, s_r.acc} + {1'b0, cfg_in.frac_word};
    assign period_end = cfg_in.exact_en && (s_r.cnt == cfg_in.step_div - 24'h000001);

    // Next state: wrap at 2^24, restart after each exact period
    always_comb begin
        s_nxt = s_r;
        s_nxt.strobe = tick_in;
        if (!run_in) begin
            s_nxt.acc = 24'h000000;
            s_nxt.cnt = 24'h000000;
            s_nxt.carry = 1'b0;
        end else if (tick_in) begin
            s_nxt.carry = sum[24];
            if (period_end) begin
                // Full-length accumulator, realigned every step_div cycles
                s_nxt.acc = 24'h000000;
                s_nxt.cnt = 24'h000000;
            end else begin
                s_nxt.acc = sum[23:0];
                s_nxt.cnt = cfg_in.exact_en ? s_r.cnt + 24'h000001 : 24'h000000;
            end
        end
    end

    // State register
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign carry_out = s_r.carry;
    assign strobe_out = s_r.strobe;
    assign phase_out = s_r.acc;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_wrap;
        @(posedge clock_in) disable iff (!resetn_in)
        (run_in && tick_in && !period_end) |=>
            ({s_r.carry, s_r.acc} == $past(sum));
    endproperty
    a_wrap: assert property (p_wrap) else $error("accumulator wrap wrong");

    property p_restart;
        @(posedge clock_in) disable iff (!resetn_in)
        (run_in && tick_in && period_end) |=>
            (s_r.acc == 24'h000000) && (s_r.cnt == 24'h000000);
    endproperty
    a_restart: assert property (p_restart) else $error("exact period restart missed");

endmodule
